/* File: scp_params.svh */
/*
  Constants for the serial control port: frame length, output widths and
  the reset values of the held words.
  Assumes inclusion by the port's package, design module and checker only.
*/
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SCP_FRAME_BITS   16
`define SCP_CNT_BITS     5
`define SCP_SEL_BITS     2
`define SCP_SEL_LSB      0
`define SCP_NUM_SENSE    3
`define SCP_WORD_RESET   16'h0000
`define SCP_SEL_RESET    2'h0

`endif

/* File: scp_pkg.sv */
/*
  Types for the serial control port.
  Assumes scp_params.svh is on the include path.
*/
`include "scp_params.svh"

package scp_pkg;

  // ----------------------------------------------------------------------
  // Words and pin groups
  // ----------------------------------------------------------------------
  typedef logic [`SCP_FRAME_BITS-1:0] scp_word_t;

  // Serial pins from the master, sampled by the port
  typedef struct packed {
    logic chip_select_low;
    logic serial_clk;
    logic serial_in_line;
  } scp_pins_t;

  // Serial output pin, enable low while driving
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe_n;
  } scp_out_t;

  // Frame engine states
  typedef enum logic [2:0] {
    SCP_IDLE  = 3'b001,
    SCP_SHIFT = 3'b010,
    SCP_DONE  = 3'b100
  } scp_state_t;

endpackage : scp_pkg

/* File: scp_sync.sv */
/*
  Two-flop synchroniser, one lane per bit of a vector.
  Assumes inputs are asynchronous to clk; reset value is a parameter.
*/
`timescale 1ns/1ps

module scp_sync #(
  parameter int         WIDTH = 3,
  parameter [WIDTH-1:0] RST   = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // Per-bit double flop
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_lane
      logic meta_r;
      // First flop is read only by the second
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          meta_r      <= RST[g];
          sync_out[g] <= RST[g];
        end
        else
        begin
          meta_r      <= async_in[g];
          sync_out[g] <= meta_r;
        end
      end
    end
  endgenerate

endmodule : scp_sync

/* File: scp_port.sv */
/*
  Serial control port of a multi-output driver: 16-bit slave shift port,
  LSB-first in on falling serial clock, MSB-first out on rising serial
  clock, output floated while deselected, plus the sense mux selection.
  Assumes the master keeps the serial clock low around select edges and
  that each serial clock half spans at least four ref_clk cycles, since
  the output bit appears four cycles after the pin rises.
*/
// Notes on behaviour
// - Traffic counts only while select is low; ignored while high.
// - Shift register advances only on edges of the master's clock.
// - Serial input is sampled on each falling serial clock edge.
// - Received words arrive least significant bit first.
// - Input data is accepted only while selected.
// - Serial output changes on each rising serial clock edge after the first; bit 15 is already on the line at the first.
// - Outgoing words leave most significant bit first.
// - Serial output floats while select is high, driven while low.
// - Sense output follows the switch chosen by the mux select bits.
// - A frame is sixteen bits, sixteen clock pulses per selection.
`timescale 1ns/1ps
`include "scp_params.svh"

module scp_port (
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire scp_pkg::scp_pins_t           pins,
  input  wire scp_pkg::scp_word_t           resp_word,
  output scp_pkg::scp_out_t                 out_pin,
  output scp_pkg::scp_word_t                ctrl_word,
  output logic                              ctrl_valid,
  output logic                              frame_error,
  output logic [`SCP_SEL_BITS-1:0]          sense_mux_select,
  output logic [`SCP_NUM_SENSE-1:0]         sense_route
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  scp_pkg::scp_pins_t  pins_s;
  logic                cs_d_r;
  logic                sck_d_r;
  logic                selected;
  logic                cs_fall;
  logic                cs_rise;
  logic                sck_rise;
  logic                sck_fall;

  // Select idles high so reset looks deselected
  scp_sync #(
    .WIDTH (3),
    .RST   (3'b100)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (pins),
    .sync_out (pins_s)
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r  <= pins_s.chip_select_low;
      sck_d_r <= pins_s.serial_clk;
    end
  end

  assign selected = !pins_s.chip_select_low;
  assign cs_fall  = cs_d_r && !pins_s.chip_select_low;
  assign cs_rise  = !cs_d_r && pins_s.chip_select_low;
  // Clock edges only count while selected, so stray clocks are ignored
  assign sck_rise = selected && !cs_fall && !sck_d_r && pins_s.serial_clk;
  assign sck_fall = selected && !cs_fall && sck_d_r && !pins_s.serial_clk;

  // ----------------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------------
  scp_pkg::scp_state_t     state_r;
  scp_pkg::scp_state_t     state_nxt;
  logic [`SCP_CNT_BITS-1:0] bit_cnt_r;
  scp_pkg::scp_word_t      rx_r;
  scp_pkg::scp_word_t      tx_r;

  // Count falling edges; a frame is complete at exactly sixteen
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      scp_pkg::SCP_IDLE:
        if (cs_fall)
          state_nxt = scp_pkg::SCP_SHIFT;
      scp_pkg::SCP_SHIFT:
        if (cs_rise)
          state_nxt = scp_pkg::SCP_IDLE;
        else if (sck_fall && bit_cnt_r == 5'(`SCP_FRAME_BITS - 1))
          state_nxt = scp_pkg::SCP_DONE;
      scp_pkg::SCP_DONE:
        if (cs_rise)
          state_nxt = scp_pkg::SCP_IDLE;
      default:
        state_nxt = scp_pkg::SCP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= scp_pkg::SCP_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bit counter; saturates so extra pulses mark the frame bad
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      bit_cnt_r <= '0;
    else if (cs_fall)
      bit_cnt_r <= '0;
    else if (sck_fall && bit_cnt_r != 5'(`SCP_FRAME_BITS + 1))
      bit_cnt_r <= bit_cnt_r + 5'd1;
  end

  // ----------------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------------
  // Shift right, new bit at the top: first bit ends in bit 0
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rx_r <= `SCP_WORD_RESET;
    else if (sck_fall)
      rx_r <= {pins_s.serial_in_line, rx_r[`SCP_FRAME_BITS-1:1]};
  end

  // ----------------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------------
  // Load at select fall so bit 15 is on the line before the first edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tx_r <= `SCP_WORD_RESET;
    else if (cs_fall)
      tx_r <= resp_word;
    else if (sck_rise && bit_cnt_r != 5'd0)
      tx_r <= {tx_r[`SCP_FRAME_BITS-2:0], 1'b0};
  end

  // Output pin registered; enable low only while selected
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_pin.serial_out      <= 1'b0;
      out_pin.serial_out_oe_n <= 1'b1;
    end
    else
    begin
      out_pin.serial_out      <= tx_r[`SCP_FRAME_BITS-1];
      out_pin.serial_out_oe_n <= !selected || cs_rise;
    end
  end

  // ----------------------------------------------------------------------
  // Word hand-off at select rise
  // ----------------------------------------------------------------------
  // Apply only a frame of exactly sixteen pulses; else flag the error
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_word   <= `SCP_WORD_RESET;
      ctrl_valid  <= 1'b0;
      frame_error <= 1'b0;
    end
    else
    begin
      ctrl_valid  <= 1'b0;
      frame_error <= 1'b0;
      if (cs_rise)
      begin
        if (state_r == scp_pkg::SCP_DONE && bit_cnt_r == 5'(`SCP_FRAME_BITS))
        begin
          ctrl_word  <= rx_r;
          ctrl_valid <= 1'b1;
        end
        else if (state_r != scp_pkg::SCP_IDLE)
          frame_error <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Current-sense multiplexer
  // ----------------------------------------------------------------------
  // Select bits taken from the applied word; routing follows at once
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sense_mux_select <= `SCP_SEL_RESET;
    else if (cs_rise && state_r == scp_pkg::SCP_DONE
             && bit_cnt_r == 5'(`SCP_FRAME_BITS))
      sense_mux_select <= rx_r[`SCP_SEL_LSB +: `SCP_SEL_BITS];
  end

  // One-hot route; an unused code selects no switch
  genvar s;
  generate
    for (s = 0; s < `SCP_NUM_SENSE; s++)
    begin : g_route
      assign sense_route[s] = (sense_mux_select == `SCP_SEL_BITS'(s + 1));
    end
  endgenerate

endmodule : scp_port

/* File: scp_port_sva.sv */
/*
  Checker for the serial control port, bound to scp_port.
  Assumes the serial clock half period spans at least 3 ref_clk cycles.
*/
`timescale 1ns/1ps
`include "scp_params.svh"

module scp_port_sva (
  input wire logic                      ref_clk,
  input wire logic                      rstn,
  input wire scp_pkg::scp_pins_t        pins,
  input wire scp_pkg::scp_word_t        resp_word,
  input wire scp_pkg::scp_out_t         out_pin,
  input wire scp_pkg::scp_word_t        ctrl_word,
  input wire logic                      ctrl_valid,
  input wire logic                      frame_error,
  input wire logic [`SCP_SEL_BITS-1:0]  sense_mux_select,
  input wire logic [`SCP_NUM_SENSE-1:0] sense_route
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------------
  // Select steps, long enough to cover the synchroniser delay
  // ----------------------------------------------------------------------
  sequence s_desel;
    pins.chip_select_low [*5];
  endsequence
  sequence s_sel;
    !pins.chip_select_low [*6];
  endsequence
  a_float_desel: assert property (s_desel |-> out_pin.serial_out_oe_n)
    else $error("serial out driven while deselected");
  a_drive_sel: assert property (s_sel |-> !out_pin.serial_out_oe_n)
    else $error("serial out not driven while selected");
  a_out_on_rise: assert property ($changed(out_pin.serial_out) && !out_pin.serial_out_oe_n
    && !$past(out_pin.serial_out_oe_n) && !$past(out_pin.serial_out_oe_n, 2)
    |-> $past(pins.serial_clk, 2))
    else $error("serial out moved without a clock rise");
  a_route_map: assert property (sense_route == ((sense_mux_select == 2'h0) ? 3'h0
    : 3'(3'h1 << (sense_mux_select - 2'h1))))
    else $error("sense route does not match select");
  a_sel_from_word: assert property (ctrl_valid |-> sense_mux_select == ctrl_word[1:0])
    else $error("sense select not taken from word");
  a_word_on_valid: assert property ($changed(ctrl_word) |-> ctrl_valid)
    else $error("control word changed without valid");
  a_valid_desel: assert property (ctrl_valid |-> $past(pins.chip_select_low, 2) ##1 !ctrl_valid)
    else $error("valid not a pulse after deselect");
  a_err_alone: assert property (frame_error |-> !ctrl_valid ##1 !frame_error)
    else $error("frame error not a lone pulse");
endmodule : scp_port_sva

bind scp_port scp_port_sva i_sva (.ref_clk(ref_clk), .rstn(rstn), .pins(pins),
  .resp_word(resp_word), .out_pin(out_pin), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
  .frame_error(frame_error), .sense_mux_select(sense_mux_select), .sense_route(sense_route));

/* File: scp_master_model.sv */
/*
  Serial master model driving the port pins from ref_clk-timed steps.
  Assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ps

module scp_master_model (
  input  wire logic              ref_clk,
  input  wire scp_pkg::scp_out_t out_pin,
  output scp_pkg::scp_pins_t     pins
);
  logic last_r;
  logic so_line;
  // A floated line shows the inverse of its last level, never a stale bit
  always @(posedge ref_clk) if (!out_pin.serial_out_oe_n) last_r <= out_pin.serial_out;
  assign so_line = out_pin.serial_out_oe_n ? ~last_r : out_pin.serial_out;
  initial pins = 3'b100;
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  // One frame of npls pulses; sel low leaves select high throughout
  task automatic xfer(input scp_pkg::scp_word_t tx, input int npls, input logic sel,
                      output scp_pkg::scp_word_t rx);
    rx = 16'h0000;
    pins.chip_select_low = !sel;
    wt(8);
    for (int i = 0; i < npls; i++)
    begin
      pins.serial_clk = 1'b1;
      pins.serial_in_line = tx[i];
      wt(4);
      rx = {rx[14:0], so_line};
      pins.serial_clk = 1'b0;
      wt(4);
    end
    pins.serial_in_line = 1'b0;
    pins.chip_select_low = 1'b1;
    wt(12);
  endtask : xfer
endmodule : scp_master_model

/* File: tb_serial_control_port_pins.sv */
/*
  Testbench for scp_port with the serial master model.
  Assumes a 100 ns ref_clk and an 800 ns serial clock.
*/
`timescale 1ns/1ps

module tb_serial_control_port_pins;
  logic               ref_clk = 1'b0;
  logic               rstn = 1'b0;
  scp_pkg::scp_pins_t pins;
  scp_pkg::scp_word_t resp_word = 16'h0000;
  scp_pkg::scp_out_t  out_pin;
  scp_pkg::scp_word_t ctrl_word;
  scp_pkg::scp_word_t rx;
  logic               ctrl_valid;
  logic               frame_error;
  logic [1:0]         sense_mux_select;
  logic [2:0]         sense_route;
  int                 n_fail = 0;
  int                 compares = 0;
  int                 n_valid = 0;
  int                 n_err = 0;
  int                 cycles = 0;
  always #50 ref_clk = ~ref_clk;
  scp_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .pins(pins), .resp_word(resp_word),
    .out_pin(out_pin), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
    .frame_error(frame_error), .sense_mux_select(sense_mux_select), .sense_route(sense_route));
  scp_master_model i_master (.ref_clk(ref_clk), .out_pin(out_pin), .pins(pins));
  // Pulse counters and a hang limit well above the seven frames
  always @(posedge ref_clk)
  begin
    cycles++;
    if (ctrl_valid === 1'b1) n_valid++;
    if (frame_error === 1'b1) n_err++;
    if (cycles == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  // Good frame: word in, response out, select code applied
  task automatic t_good(input scp_pkg::scp_word_t w);
    int nv;
    nv = n_valid;
    resp_word = ~w;
    i_master.xfer(w, 16, 1'b1, rx);
    check(rx, ~w, "response");
    check(ctrl_word, w, "word");
    check(16'(n_valid), 16'(nv + 1), "valid count");
    check(16'(sense_mux_select), 16'(w[1:0]), "select");
    check(16'(sense_route), (w[1:0] == 2'h0) ? 16'h0000 : 16'h0001 << (w[1:0] - 1), "route");
    check(16'(out_pin.serial_out_oe_n), 16'h0001, "float");
    $display("test good %h done", w);
  endtask : t_good
  // Short frame, long frame and traffic while deselected all leave the word alone
  task automatic t_bad(input int npls, input logic sel);
    scp_pkg::scp_word_t w;
    int nv;
    int ne;
    w = ctrl_word;
    nv = n_valid;
    ne = n_err;
    i_master.xfer(16'h5A5A, npls, sel, rx);
    check(ctrl_word, w, "word kept");
    check(16'(n_valid), 16'(nv), "no valid");
    check(16'(n_err), 16'(ne + 32'(sel)), "error count");
    $display("test bad %0d %b done", npls, sel);
  endtask : t_bad
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    i_master.wt(4);
    check(ctrl_word, 16'h0000, "reset word");
    check(16'(out_pin.serial_out_oe_n), 16'h0001, "reset float");
    t_good(16'h8B54);
    t_good(16'h1235);
    t_good(16'hC3A6);
    t_good(16'h7E0F);
    t_bad(15, 1'b1);
    t_bad(17, 1'b1);
    t_bad(16, 1'b0);
    tally_and_finish();
  end
endmodule : tb_serial_control_port_pins
